// ==== status_map.svh ====
// Bit positions, reset values and fixed answers of the status system.
// Assumes inclusion by the status module only; the status package does not include it.
`ifndef STATUS_MAP_SVH
`define STATUS_MAP_SVH

// Event latch bit positions
`define EV_POWER_ON      7
`define EV_CMD_ERR       5
`define EV_EXEC_ERR      4
`define EV_QUERY_ERR     2
`define EV_OP_DONE       0

// Status byte bit positions
`define SB_SAMPLE_RAMP   7
`define SB_MASTER        6
`define SB_EVENT_SUM     5
`define SB_OVERLOAD      4
`define SB_ALARM         3
`define SB_MEAS_VALID    2
`define SB_CTRL_VALID    1
`define SB_WARMUP_RAMP   0

// Reset values: only the power-on flag comes up set
`define EVENT_LATCH_RST  8'h80
`define EVENT_MASK_RST   8'h00
`define SERVICE_MASK_RST 8'h00

// Answer placed in the output buffer once pending work ends
`define OP_DONE_ANSWER   8'h01

// Service mask bits that may feed the master summary
`define MASTER_SRC_MASK  8'hBF

`endif

// ==== status_pkg.sv ====
// Types shared by the status-reporting block and its testbench.
// Assumes status_map.svh is on the include path.
package status_pkg;

  // Common commands and the serial poll, as decoded upstream
  typedef enum logic [3:0] {
    CMD_NONE        = 4'b0000,
    CMD_EVENT_READ  = 4'b0001,
    CMD_EMASK_WRITE = 4'b0010,
    CMD_EMASK_READ  = 4'b0011,
    CMD_SMASK_WRITE = 4'b0100,
    CMD_SMASK_READ  = 4'b0101,
    CMD_STATUS_READ = 4'b0110,
    CMD_CLEAR       = 4'b0111,
    CMD_OP_NOTIFY   = 4'b1000,
    CMD_OP_QUERY    = 4'b1001,
    CMD_RESET       = 4'b1010,
    CMD_SERIAL_POLL = 4'b1011
  } cmd_e;

  // Whole state of the status block
  typedef struct packed {
    logic [7:0] event_status_latch;
    logic [7:0] event_report_mask;
    logic [7:0] service_request_mask;
    logic       master_prev;
    logic       request_service_state;
    logic       op_notify_armed;
    logic       op_query_wait;
    logic       resp_valid;
    logic [7:0] resp_data;
  } state_s;

endpackage : status_pkg

// ==== status_reporting_service_request.sv ====
// Status reporting and service request logic of the instrument.
// Assumes commands arrive decoded on one clock with the condition flags;
// formatting answers as decimal text is left to the command firmware.
`timescale 1ns/1ps
`include "status_map.svh"

module status_reporting_service_request (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_cmd_valid,
  input  wire status_pkg::cmd_e i_cmd_code,
  input  wire logic [7:0]       i_cmd_data,
  output logic                  o_cmd_ready,
  output logic                  o_resp_valid,
  output logic [7:0]            o_resp_data,
  output logic                  o_srq,
  input  wire logic             i_command_error,
  input  wire logic             i_execution_error,
  input  wire logic             i_query_error,
  input  wire logic             i_ops_pending,
  input  wire logic             i_sample_ramp_done,
  input  wire logic             i_warmup_ramp_done,
  input  wire logic             i_current_source_overload,
  input  wire logic             i_common_mode_overload,
  input  wire logic             i_differential_overload,
  input  wire logic             i_mixer_overload,
  input  wire logic [3:0]       i_range_fault,
  input  wire logic             i_input_alarm,
  input  wire logic             i_alarm_visible,
  input  wire logic             i_measure_reading_valid,
  input  wire logic             i_control_reading_valid
);
  import status_pkg::*;

  state_s     st_q;
  state_s     st_d;
  logic       take;
  logic       cmd_ok;
  logic [7:0] event_set;
  logic       event_summary_bit;
  logic       input_overload_flag;
  logic       alarm_shown;
  logic [7:0] sum_bits;
  logic       master_summary_bit;
  logic [7:0] status_summary_byte;
  logic       master_rise;

  // Any mask bit meeting its flag; used for both summaries
  function automatic logic masked_any(input logic [7:0] flags,
                                      input logic [7:0] mask);
    masked_any = |(flags & mask);
  endfunction : masked_any

  // Bus is held only during a done query; reset still gets through
  assign o_cmd_ready = !st_q.op_query_wait;
  assign cmd_ok      = o_cmd_ready || (i_cmd_code == CMD_RESET);
  assign take        = i_ce && i_cmd_valid && cmd_ok;

  // Hardware event sources this cycle
  always_comb begin
    event_set                = 8'h00;
    event_set[`EV_CMD_ERR]   = i_command_error;
    event_set[`EV_EXEC_ERR]  = i_execution_error;
    event_set[`EV_QUERY_ERR] = i_query_error;
    event_set[`EV_OP_DONE]   = st_q.op_notify_armed && !i_ops_pending;
  end

  // Summaries are plain gates so a cleared latch drops them at once
  assign event_summary_bit = masked_any(st_q.event_status_latch,
                                        st_q.event_report_mask);
  assign input_overload_flag = i_current_source_overload
                            || i_common_mode_overload
                            || i_differential_overload
                            || i_mixer_overload
                            || (|i_range_fault);
  assign alarm_shown = i_input_alarm && i_alarm_visible;

  // Summary bits of the status byte, master bit left out
  always_comb begin
    sum_bits                  = 8'h00;
    sum_bits[`SB_SAMPLE_RAMP] = i_sample_ramp_done;
    sum_bits[`SB_EVENT_SUM]   = event_summary_bit;
    sum_bits[`SB_OVERLOAD]    = input_overload_flag;
    sum_bits[`SB_ALARM]       = alarm_shown;
    sum_bits[`SB_MEAS_VALID]  = i_measure_reading_valid;
    sum_bits[`SB_CTRL_VALID]  = i_control_reading_valid;
    sum_bits[`SB_WARMUP_RAMP] = i_warmup_ramp_done;
  end

  // Master follows the masked summaries with no latch of its own
  assign master_summary_bit = masked_any(sum_bits,
    st_q.service_request_mask & `MASTER_SRC_MASK);

  always_comb begin
    status_summary_byte             = sum_bits;
    status_summary_byte[`SB_MASTER] = master_summary_bit;
  end

  // Only an edge requests service, so a held master cannot repeat it
  assign master_rise = master_summary_bit && !st_q.master_prev;

  // Next state: events set, commands clear; a set beats a same-cycle clear
  always_comb begin
    st_d            = st_q;
    // Pulse drops only on an enabled edge, so a frozen answer stays put
    if (i_ce) begin
      st_d.resp_valid  = 1'b0;
      st_d.master_prev = master_summary_bit;
      if (take) begin
        case (i_cmd_code)
          CMD_EVENT_READ: begin
            st_d.resp_valid         = 1'b1;
            st_d.resp_data          = st_q.event_status_latch;
            st_d.event_status_latch = 8'h00;
          end
          CMD_EMASK_WRITE: begin
            st_d.event_report_mask = i_cmd_data;
          end
          CMD_EMASK_READ: begin
            st_d.resp_valid = 1'b1;
            st_d.resp_data  = st_q.event_report_mask;
          end
          CMD_SMASK_WRITE: begin
            st_d.service_request_mask = i_cmd_data;
          end
          CMD_SMASK_READ: begin
            st_d.resp_valid = 1'b1;
            st_d.resp_data  = st_q.service_request_mask;
          end
          CMD_STATUS_READ: begin
            st_d.resp_valid = 1'b1;
            st_d.resp_data  = status_summary_byte;
          end
          CMD_CLEAR: begin
            st_d.event_status_latch = 8'h00;
          end
          CMD_OP_NOTIFY: begin
            st_d.op_notify_armed = 1'b1;
          end
          CMD_OP_QUERY: begin
            st_d.op_query_wait = 1'b1;
          end
          CMD_RESET: begin
            // Abandons a done query; it is still answered if work ends in the same cycle
            st_d.op_query_wait   = 1'b0;
            st_d.op_notify_armed = 1'b0;
          end
          CMD_SERIAL_POLL: begin
            st_d.resp_valid = 1'b1;
            st_d.resp_data  = {status_summary_byte[7],
                               st_q.request_service_state,
                               status_summary_byte[5:0]};
            st_d.request_service_state = 1'b0;
          end
          default: begin
            st_d.resp_valid = 1'b0;
          end
        endcase
      end
      // Done query answers once work ends; no event flag is touched
      if (st_q.op_query_wait && !i_ops_pending) begin
        st_d.op_query_wait = 1'b0;
        st_d.resp_valid    = 1'b1;
        st_d.resp_data     = `OP_DONE_ANSWER;
      end
      if (event_set[`EV_OP_DONE]) begin
        st_d.op_notify_armed = 1'b0;
      end
      st_d.event_status_latch = st_d.event_status_latch | event_set;
      if (master_rise) begin
        st_d.request_service_state = 1'b1;
      end
    end
  end

  // State register; reset is a power-on, so the power flag comes up set
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q                      <= '0;
      st_q.event_status_latch   <= `EVENT_LATCH_RST;
      st_q.event_report_mask    <= `EVENT_MASK_RST;
      st_q.service_request_mask <= `SERVICE_MASK_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign o_resp_valid = st_q.resp_valid;
  assign o_resp_data  = st_q.resp_data;
  assign o_srq        = st_q.request_service_state;

  // Command error lands in the latch next cycle
  cmd_err_set_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_command_error |=> st_q.event_status_latch[`EV_CMD_ERR])
    else $error("command error flag not set");

  // Execution error lands in the latch next cycle
  exec_err_set_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_execution_error |=> st_q.event_status_latch[`EV_EXEC_ERR])
    else $error("execution error flag not set");

  // Query error lands in the latch next cycle
  query_err_set_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && i_query_error |=> st_q.event_status_latch[`EV_QUERY_ERR])
    else $error("query error flag not set");

  // Armed notify sets bit 0 once work has ended
  op_done_set_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && st_q.op_notify_armed && !i_ops_pending
    |=> st_q.event_status_latch[`EV_OP_DONE] && !st_q.op_notify_armed)
    else $error("operation done flag not set");

  // Event read answers old contents and leaves only new events
  event_read_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_EVENT_READ && event_set == 8'h00
    |=> o_resp_valid && o_resp_data == $past(st_q.event_status_latch)
        && st_q.event_status_latch == 8'h00)
    else $error("event read did not answer and clear");

  // Event summary tracks the masked latch
  event_sum_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    status_summary_byte[`SB_EVENT_SUM]
      == (|(st_q.event_status_latch & st_q.event_report_mask)))
    else $error("event summary bit wrong");

  // Master rising edge raises the line on the next edge
  srq_rise_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && master_summary_bit && !st_q.master_prev |=> o_srq)
    else $error("service request not raised");

  // Poll drops the request unless a fresh rise comes with it
  poll_clear_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_SERIAL_POLL && !master_rise
    |=> !o_srq && o_resp_valid)
    else $error("serial poll did not drop request");

  // Without a new edge the line never rises on its own
  srq_no_repeat_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !o_srq && !(i_ce && master_rise) |=> !o_srq)
    else $error("service request raised without an edge");

  // Status read answers master in bit 6 and clears nothing
  status_read_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_STATUS_READ
    |=> o_resp_data[`SB_MASTER] == $past(master_summary_bit)
        && ($past(st_q.event_status_latch)
            & ~st_q.event_status_latch) == 8'h00)
    else $error("status read wrong or destructive");

  // Done query holds the bus, then answers one
  op_query_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    i_ce && st_q.op_query_wait && !i_ops_pending
    |-> !o_cmd_ready ##1 o_resp_valid && o_resp_data == `OP_DONE_ANSWER
        && o_cmd_ready)
    else $error("done query answer wrong");

  // Event mask write lands on the next edge
  emask_load_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_EMASK_WRITE
    |=> st_q.event_report_mask == $past(i_cmd_data))
    else $error("event mask not loaded");

  // Service mask write lands on the next edge
  smask_load_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_SMASK_WRITE
    |=> st_q.service_request_mask == $past(i_cmd_data))
    else $error("service mask not loaded");

  // Clear empties the latch when no event races it
  clear_cmd_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_CLEAR && event_set == 8'h00
    |=> st_q.event_status_latch == 8'h00)
    else $error("clear left events latched");

  // Any overload source shows in bit 4 of the answer
  overload_bit_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_STATUS_READ
    |=> o_resp_data[`SB_OVERLOAD] == $past(i_current_source_overload
        || i_common_mode_overload || i_differential_overload
        || i_mixer_overload || (|i_range_fault)))
    else $error("overload bit wrong");

  // Alarm shows only while it is visible
  alarm_bit_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_STATUS_READ
    |=> o_resp_data[`SB_ALARM] == $past(i_input_alarm && i_alarm_visible))
    else $error("alarm bit wrong");

  // Master in the answer matches the other answered bits under the mask
  master_sum_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_STATUS_READ
    |=> o_resp_data[`SB_MASTER]
        == (|(o_resp_data & $past(st_q.service_request_mask) & `MASTER_SRC_MASK)))
    else $error("master summary wrong");

  // Poll answers the request state in bit 6
  poll_answer_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    take && i_cmd_code == CMD_SERIAL_POLL
    |=> o_resp_data[`SB_MASTER] == $past(st_q.request_service_state))
    else $error("poll answer bit 6 wrong");

  // Low enable freezes every bit of state
  freeze_hold_a : assert property (
    @(posedge i_clk) disable iff (!i_rst_n)
    !i_ce |=> $stable(st_q))
    else $error("state moved while frozen");

endmodule : status_reporting_service_request

// ==== remote_controller.sv ====
// Bus controller model: offers decoded common commands and serial polls.
// Assumes the status block samples commands on the rising edge of i_clk.
`timescale 1ns/1ps
module remote_controller (
  input  wire logic        i_clk,
  input  wire logic        i_cmd_ready,
  input  wire logic        i_resp_valid,
  input  wire logic [7:0]  i_resp_data,
  output status_pkg::cmd_e o_cmd_code,
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd_data
);
  import status_pkg::*;

  // Idle from time zero
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = CMD_NONE;
    o_cmd_data  = 8'h00;
  end

  // One command: held until taken, then the answer is watched for wait_n cycles
  task automatic send(input cmd_e c, input logic [7:0] d, input int wait_n,
                      output logic [7:0] r, output logic got);
    int n;
    got         = 1'b0;
    r           = 8'h00;
    o_cmd_valid = 1'b1;
    o_cmd_code  = c;
    o_cmd_data  = d;
    // Nothing but a reset may cut into a stalled done query
    for (n = 0; i_cmd_ready !== 1'b1 && c != CMD_RESET && n < 100; n++) begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_code  = CMD_NONE;
    o_cmd_data  = ~d; // Released data never keeps the last value
    for (n = 0; n < wait_n && !got; n++) begin
      if (i_resp_valid === 1'b1) begin
        got = 1'b1;
        r   = i_resp_data;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
    // One free edge keeps back-to-back requests apart
    @(posedge i_clk);
    #1;
  endtask : send
endmodule : remote_controller

// ==== tb_top.sv ====
// Self-checking bench for the status reporting and service request block.
// Assumes remote_controller drives the command port; the bench drives conditions.
`timescale 1ns/1ps
module tb_top;
  import status_pkg::*;
  logic       clk, rst_n, ce, pend, alarm, vis;
  logic       cmd_valid, cmd_ready, resp_valid, srq;
  logic [2:0] evs;
  logic [3:0] cond;
  logic [7:0] ovl, cmd_data, resp_data;
  cmd_e       cmd_code;
  int         n_errors = 0;
  int         compares = 0;
  int         cyc      = 0;

  // Clock enable driven by the bench so freezing is exercised
  status_reporting_service_request dut_u (
    .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_cmd_valid(cmd_valid),
    .i_cmd_code(cmd_code), .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready),
    .o_resp_valid(resp_valid), .o_resp_data(resp_data), .o_srq(srq),
    .i_command_error(evs[0]), .i_execution_error(evs[1]), .i_query_error(evs[2]),
    .i_ops_pending(pend), .i_sample_ramp_done(cond[0]), .i_warmup_ramp_done(cond[1]),
    .i_current_source_overload(ovl[0]), .i_common_mode_overload(ovl[1]),
    .i_differential_overload(ovl[2]), .i_mixer_overload(ovl[3]),
    .i_range_fault(ovl[7:4]), .i_input_alarm(alarm), .i_alarm_visible(vis),
    .i_measure_reading_valid(cond[2]), .i_control_reading_valid(cond[3]));

  remote_controller ctl_u (
    .i_clk(clk), .i_cmd_ready(cmd_ready), .i_resp_valid(resp_valid),
    .i_resp_data(resp_data), .o_cmd_code(cmd_code), .o_cmd_valid(cmd_valid),
    .o_cmd_data(cmd_data));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t value mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt

  task automatic rd(input cmd_e c, input logic [7:0] exp);
    logic [7:0] r;
    logic       got;
    ctl_u.send(c, 8'h00, 1, r, got);
    chk({7'h00, got}, 8'h01);
    chk(r, exp);
  endtask : rd

  task automatic wr(input cmd_e c, input logic [7:0] d);
    logic [7:0] r;
    logic       got;
    ctl_u.send(c, d, 0, r, got);
  endtask : wr

  // One-cycle event pulse: bit 0 command, 1 execution, 2 query error
  task automatic ev(input logic [2:0] v);
    evs = v;
    wt(1);
    evs = 3'b000;
  endtask : ev

  // Second power cycle mid-run with masks loaded
  task automatic t_power;
    wr(CMD_EMASK_WRITE, 8'hFF);
    wr(CMD_SMASK_WRITE, 8'hFF);
    rst_n = 1'b0;
    wt(2);
    chk({7'h00, srq}, 8'h00);
    rst_n = 1'b1;
    rd(CMD_EVENT_READ, 8'h80);
    rd(CMD_EVENT_READ, 8'h00);
    rd(CMD_EMASK_READ, 8'h00);
    rd(CMD_SMASK_READ, 8'h00);
  endtask : t_power

  task automatic t_events;
    logic [7:0] exp_ev [3] = '{8'h20, 8'h10, 8'h04};
    for (int k = 0; k < 3; k++) begin
      ev(3'(1 << k));
      rd(CMD_EVENT_READ, exp_ev[k]);
    end
    ev(3'b111);
    rd(CMD_EVENT_READ, 8'h34);
    ev(3'b111);
    wr(CMD_CLEAR, 8'h00);
    rd(CMD_EVENT_READ, 8'h00);
    wr(CMD_EMASK_WRITE, 8'hA5);
    rd(CMD_EMASK_READ, 8'hA5);
    wr(CMD_SMASK_WRITE, 8'h5A);
    rd(CMD_SMASK_READ, 8'h5A);
    wr(CMD_SMASK_WRITE, 8'h00);
  endtask : t_events

  // Condition sources one by one, then the event summary
  task automatic t_byte;
    logic [7:0] exp_c [4] = '{8'h80, 8'h01, 8'h04, 8'h02};
    for (int k = 0; k < 4; k++) begin
      cond = 4'(1 << k);
      rd(CMD_STATUS_READ, exp_c[k]);
    end
    cond = 4'h0;
    for (int k = 0; k < 8; k++) begin
      ovl = 8'(1 << k);
      rd(CMD_STATUS_READ, 8'h10);
    end
    ovl   = 8'h00;
    alarm = 1'b1;
    rd(CMD_STATUS_READ, 8'h00);
    vis = 1'b1;
    rd(CMD_STATUS_READ, 8'h08);
    alarm = 1'b0;
    rd(CMD_STATUS_READ, 8'h00);
    vis = 1'b0;
    wr(CMD_EMASK_WRITE, 8'h20);
    ev(3'b010);
    rd(CMD_STATUS_READ, 8'h00);
    ev(3'b001);
    rd(CMD_STATUS_READ, 8'h20);
    rd(CMD_EVENT_READ, 8'h30);
    rd(CMD_STATUS_READ, 8'h00);
  endtask : t_byte

  task automatic t_srq;
    wr(CMD_SMASK_WRITE, 8'h20);
    ev(3'b001);
    chk({7'h00, srq}, 8'h00);
    wt(1);
    chk({7'h00, srq}, 8'h01);
    rd(CMD_STATUS_READ, 8'h60);
    rd(CMD_SERIAL_POLL, 8'h60);
    chk({7'h00, srq}, 8'h00);
    rd(CMD_STATUS_READ, 8'h60);
    ev(3'b001);
    wt(2);
    chk({7'h00, srq}, 8'h00);
    rd(CMD_EVENT_READ, 8'h20);
    rd(CMD_STATUS_READ, 8'h00);
    ev(3'b001);
    wt(1);
    chk({7'h00, srq}, 8'h01);
    wr(CMD_SMASK_WRITE, 8'h00);
    rd(CMD_STATUS_READ, 8'h20);
    rd(CMD_SERIAL_POLL, 8'h60);
    chk({7'h00, srq}, 8'h00);
    wr(CMD_CLEAR, 8'h00);
  endtask : t_srq

  // Notify keeps commands flowing; done query stalls the port
  task automatic t_opc;
    int n;
    pend = 1'b1;
    wr(CMD_OP_NOTIFY, 8'h00);
    rd(CMD_STATUS_READ, 8'h00);
    rd(CMD_EVENT_READ, 8'h00);
    pend = 1'b0;
    wt(2);
    rd(CMD_EVENT_READ, 8'h01);
    pend = 1'b1;
    wr(CMD_OP_QUERY, 8'h00);
    chk({7'h00, cmd_ready}, 8'h00);
    pend = 1'b0;
    for (n = 0; resp_valid !== 1'b1 && n < 10; n++) wt(1);
    chk({7'h00, resp_valid}, 8'h01);
    chk(resp_data, 8'h01);
    rd(CMD_EVENT_READ, 8'h00);
    pend = 1'b1;
    wr(CMD_OP_QUERY, 8'h00);
    wr(CMD_RESET, 8'h00);
    chk({6'h00, cmd_ready, resp_valid}, 8'h02);
    pend = 1'b0;
  endtask : t_opc

  // Frozen block ignores events and commands alike
  task automatic t_freeze;
    ce = 1'b0;
    ev(3'b111);
    wr(CMD_EMASK_WRITE, 8'h5A);
    ce = 1'b1;
    rd(CMD_EVENT_READ, 8'h00);
    rd(CMD_EMASK_READ, 8'h20);
  endtask : t_freeze

  task automatic complete_run;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Main sequence: power-on reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    ce    = 1'b1;
    pend  = 1'b0;
    alarm = 1'b0;
    vis   = 1'b0;
    evs   = 3'b000;
    cond  = 4'h0;
    ovl   = 8'h00;
    wt(5);
    rst_n = 1'b1;
    t_power();
    t_events();
    t_byte();
    t_srq();
    t_opc();
    t_freeze();
    complete_run();
  end
endmodule : tb_top
